// ==== pkg/bridge_params.svh ====
`ifndef BRIDGE_PARAMS_SVH
`define BRIDGE_PARAMS_SVH
// Bus widths
`define FETCH_AW 22
`define DATA_AW 32
`define DATA_W 32
`define PERIPH_AW 16
// Address decode
`define MEM1_BASE 32'h0000_8000
`define PF1_BASE 32'h0000_6000
`define PF1_LAST 32'h0000_6fff
`define PF2_BASE 32'h0000_7000
`define PF2_LAST 32'h0000_7fff
// Target codes
`define T_MEM0 2'h0
`define T_MEM1 2'h1
`define T_PERIPH 2'h2
// Request class bit positions, highest priority first
`define CL_DWR 0
`define CL_PWR 1
`define CL_DRD 2
`define CL_PRD 3
`define CL_FETCH 4
`define NUM_CLASS 5
// Peripheral read wait states
`define PF_RD_WAITS 2'h2
`endif

// ==== pkg/bridge_pkg.sv ====
package bridge_pkg;
  typedef enum logic [0:0] {
    PB_IDLE    = 1'b0,
    PB_RD_WAIT = 1'b1
  } pbus_state_e;
  typedef logic [1:0] target_t;
  typedef logic [4:0] class_vec_t;
endpackage

// ==== core/fixed_prio_arb.sv ====
`timescale 1ns/100ps
module fixed_prio_arb (
  // Requests, bit 0 ranks highest
  input logic [$bits(bridge_pkg::class_vec_t)-1:0] req,
  // One-hot grant
  output logic [$bits(bridge_pkg::class_vec_t)-1:0] gnt
);
  import bridge_pkg::*;
  // Lowest set bit wins; carry of the add isolates it
  assign gnt = req & (~req + class_vec_t'(1));
endmodule

// ==== core/memory_bus_priority_bridge.sv ====
`timescale 1ns/100ps
`include "bridge_params.svh"
// Summary of operation
// - Fetch bus has 22 address bits and 32 data bits.
// - Operand read and write buses carry 32 address and 32 data bits.
// - Zero-wait targets complete a full 32-bit access in one cycle.
// - Fetch, operand read and operand write may all complete together.
// - Targets rank data write, program write, read, program read, fetch.
// - Never issue data write and program write in one cycle.
// - Never issue program read and fetch in one cycle.
// - Bridge merges all buses onto one 16-bit address peripheral bus.
// - Legacy peripheral region accepts 16-bit accesses only.
// - First peripheral region accepts 16-bit and 32-bit accesses.
// - Peripheral writes take zero waits, reads exactly two waits.
// - Protected write then read reaches bus in order via alignment cycle.
module memory_bus_priority_bridge #(
  parameter logic [1:0] RD_WAITS = `PF_RD_WAITS
) (
  // Clock and reset
  input logic ref_clk,
  input logic reset_n,
  // Fetch bus (fetch or program-space read)
  input logic fetch_req,
  input logic fetch_prog,
  input logic fetch_size32,
  input logic [`FETCH_AW-1:0] fetch_addr,
  output logic fetch_ready,
  output logic fetch_err,
  output logic [`DATA_W-1:0] fetch_rdata,
  // Operand read bus
  input logic rd_req,
  input logic rd_size32,
  input logic [`DATA_AW-1:0] rd_addr,
  output logic rd_ready,
  output logic rd_err,
  output logic [`DATA_W-1:0] rd_rdata,
  // Operand write bus (data or program-space write)
  input logic wr_req,
  input logic wr_prog,
  input logic wr_size32,
  input logic [`DATA_AW-1:0] wr_addr,
  input logic [`DATA_W-1:0] wr_data,
  output logic wr_ready,
  output logic wr_err,
  // Two zero-wait memory targets
  output logic [1:0] mem_cs,
  output logic [1:0] mem_we,
  output logic [1:0] mem_size32,
  output logic [1:0][`DATA_AW-1:0] mem_addr,
  output logic [1:0][`DATA_W-1:0] mem_wdata,
  input logic [1:0][`DATA_W-1:0] mem_rdata,
  // Peripheral bus
  input logic prot_en,
  output logic periph_wr,
  output logic periph_rd,
  output logic periph_size32,
  output logic [`PERIPH_AW-1:0] periph_addr,
  output logic [`DATA_W-1:0] periph_wdata,
  input logic [`DATA_W-1:0] periph_rdata
);
  import bridge_pkg::*;

  logic [`DATA_AW-1:0] f_addr32;
  target_t f_tgt;
  target_t r_tgt;
  target_t w_tgt;
  class_vec_t req_v [3];
  class_vec_t gnt_v [3];
  pbus_state_e state_q;
  pbus_state_e state_d;
  logic [1:0] cnt_q;
  logic [1:0] cnt_d;
  logic owner_q;
  logic hold_q;
  logic prot_s1_q;
  logic prot_q;
  logic periph_wr_q;
  logic periph_rd_q;
  logic periph_size32_q;
  logic [`PERIPH_AW-1:0] periph_addr_q;
  logic [`DATA_W-1:0] periph_wdata_q;

  // Address decode per bus; fetch address is zero-extended
  // fetch bus width
  assign f_addr32 = {{(`DATA_AW-`FETCH_AW){1'b0}}, fetch_addr};
  function automatic target_t decode(input logic [`DATA_AW-1:0] a);
    logic pf;
    pf = (a >= `PF1_BASE) && (a <= `PF2_LAST);
    decode = pf ? `T_PERIPH : ((a >= `MEM1_BASE) ? `T_MEM1 : `T_MEM0);
  endfunction
  assign f_tgt = decode(f_addr32);
  assign r_tgt = decode(rd_addr);
  assign w_tgt = decode(wr_addr);

  // Peripheral bridge status
  wire p_busy = (state_q != PB_IDLE);
  wire p_done = (state_q == PB_RD_WAIT) && (cnt_q == 2'h0);

  // One fixed-priority arbiter per target
  // independent targets run in parallel
  for (genvar t = 0; t < 3; t++) begin : g_tgt
    localparam target_t TT = target_t'(t);
    wire is_p = (TT == `T_PERIPH);
    wire blk_all = is_p && p_busy;
    // Alignment cycle blocks reads after a protected write
    wire blk_rd = blk_all || (is_p && hold_q);
    assign req_v[t][`CL_DWR] = wr_req && !wr_prog && (w_tgt == TT) && !blk_all;
    assign req_v[t][`CL_PWR] = wr_req && wr_prog && (w_tgt == TT) && !blk_all;
    assign req_v[t][`CL_DRD] = rd_req && (r_tgt == TT) && !blk_rd;
    assign req_v[t][`CL_PRD] = fetch_req && fetch_prog && (f_tgt == TT) &&
                               !blk_rd;
    assign req_v[t][`CL_FETCH] = fetch_req && !fetch_prog &&
                                 (f_tgt == TT) && !blk_rd;
    fixed_prio_arb u_arb (
      .req(req_v[t]),
      .gnt(gnt_v[t])
    );
  end

  // Per-bus grant, collected over the targets
  wire wr_gnt = |{gnt_v[0][`CL_PWR:`CL_DWR], gnt_v[1][`CL_PWR:`CL_DWR],
                  gnt_v[2][`CL_PWR:`CL_DWR]};
  wire rd_gnt = gnt_v[0][`CL_DRD] | gnt_v[1][`CL_DRD] | gnt_v[2][`CL_DRD];
  wire f_gnt = |{gnt_v[0][`CL_FETCH:`CL_PRD], gnt_v[1][`CL_FETCH:`CL_PRD],
                 gnt_v[2][`CL_FETCH:`CL_PRD]};

  // Memory target drive; combinational so zero-wait accesses finish
  // in the cycle they are granted
  // single-cycle 32-bit access
  for (genvar m = 0; m < 2; m++) begin : g_mem
    wire sel_w = |gnt_v[m][`CL_PWR:`CL_DWR];
    wire sel_r = gnt_v[m][`CL_DRD];
    assign mem_cs[m] = |gnt_v[m];
    assign mem_we[m] = sel_w;
    assign mem_addr[m] = sel_w ? wr_addr : (sel_r ? rd_addr : f_addr32);
    assign mem_size32[m] = sel_w ? wr_size32 : (sel_r ? rd_size32 :
                                                 fetch_size32);
    assign mem_wdata[m] = wr_data;
  end

  // Peripheral grant decode
  // all buses funnel to one port
  wire p_wr_g = |gnt_v[2][`CL_PWR:`CL_DWR];
  wire p_rd_g = |gnt_v[2][`CL_FETCH:`CL_DRD];
  wire p_drd_g = gnt_v[2][`CL_DRD];
  wire [`DATA_AW-1:0] p_addr = p_wr_g ? wr_addr :
                               (p_drd_g ? rd_addr : f_addr32);
  wire p_sz = p_wr_g ? wr_size32 : (p_drd_g ? rd_size32 : fetch_size32);
  wire p_frame2 = (p_addr >= `PF2_BASE) && (p_addr <= `PF2_LAST);
  wire p_bad = (p_wr_g || p_rd_g) && p_frame2 && p_sz;
  wire issue_wr = p_wr_g && !p_bad;
  wire issue_rd = p_rd_g && !p_bad;

  // Read wait-state sequencer
  // two waits on reads
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    unique case (state_q)
      PB_IDLE: begin
        if (issue_rd) begin
          state_d = PB_RD_WAIT;
          cnt_d = RD_WAITS;
        end
      end
      PB_RD_WAIT: begin
        if (cnt_q == 2'h0) begin
          state_d = PB_IDLE;
        end else begin
          cnt_d = cnt_q - 2'h1;
        end
      end
    endcase
  end

  // Protection pin comes from outside; two flops before use.
  // Resets on, so protection holds from the first access
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      prot_s1_q <= 1'b1;
      prot_q <= 1'b1;
    end else begin
      prot_s1_q <= prot_en;
      prot_q <= prot_s1_q;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= PB_IDLE;
      cnt_q <= 2'h0;
      owner_q <= 1'b0;
      hold_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      if (issue_rd) begin
        owner_q <= !p_drd_g;
      end
      hold_q <= issue_wr && prot_q;
    end
  end

  // Peripheral strobes and payload come from flops
  // both widths pass in first region
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      periph_wr_q <= 1'b0;
      periph_rd_q <= 1'b0;
      periph_size32_q <= 1'b0;
      periph_addr_q <= '0;
      periph_wdata_q <= '0;
    end else begin
      periph_wr_q <= issue_wr;
      periph_rd_q <= (state_d == PB_RD_WAIT);
      if (issue_wr || issue_rd) begin
        periph_addr_q <= p_addr[`PERIPH_AW-1:0];
        periph_size32_q <= p_sz;
        periph_wdata_q <= wr_data;
      end
    end
  end
  assign periph_wr = periph_wr_q;
  assign periph_rd = periph_rd_q;
  assign periph_size32 = periph_size32_q;
  assign periph_addr = periph_addr_q;
  assign periph_wdata = periph_wdata_q;

  // Answers to the CPU; a loser simply sees ready low and holds
  // stall by withholding ready
  wire r_mem = (r_tgt != `T_PERIPH);
  wire f_mem = (f_tgt != `T_PERIPH);
  assign wr_ready = wr_gnt;
  assign wr_err = p_bad && p_wr_g;
  assign rd_err = p_bad && p_drd_g;
  assign fetch_err = p_bad && p_rd_g && !p_drd_g;
  assign rd_ready = (rd_gnt && (r_mem || p_bad)) || (p_done && !owner_q);
  assign fetch_ready = (f_gnt && (f_mem || p_bad)) || (p_done && owner_q);
  assign rd_rdata = r_mem ? mem_rdata[r_tgt[0]] : periph_rdata;
  assign fetch_rdata = f_mem ? mem_rdata[f_tgt[0]] : periph_rdata;

  // Checks
  wire rw_same = rd_req && wr_req && (r_tgt == w_tgt) && r_mem;
  single_cyc_rd_a: assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    rd_req && r_mem && !(wr_req && w_tgt == r_tgt) |-> rd_ready)
    else $error("zero-wait read not completed in one cycle");
  all_three_a: assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    fetch_req && rd_req && wr_req && f_mem && r_mem && f_tgt != r_tgt &&
    w_tgt == `T_PERIPH && !p_busy && !p_bad
    |-> fetch_ready && rd_ready && wr_ready)
    else $error("parallel accesses did not complete together");
  write_first_a: assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    rw_same |-> wr_ready && !rd_ready
    ##1 (!wr_req || rd_ready || rw_same))
    else $error("write did not win over read");
  no_dual_wr_a: assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    !(mem_we[0] && mem_we[1]) && !(p_wr_g && (mem_we != 2'h0)))
    else $error("two writes issued in one cycle");
  no_dual_prd_a: assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    $onehot0({gnt_v[0][`CL_PRD], gnt_v[0][`CL_FETCH], gnt_v[1][`CL_PRD],
              gnt_v[1][`CL_FETCH], gnt_v[2][`CL_PRD],
              gnt_v[2][`CL_FETCH]}))
    else $error("program read and fetch issued together");
  legacy_16_a: assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    (periph_wr || $rose(periph_rd)) && periph_size32 |->
    !((periph_addr >= `PF2_BASE) && (periph_addr <= `PF2_LAST)))
    else $error("32-bit access reached legacy region");
  wide_ok_a: assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    issue_wr && p_sz |=> periph_wr && periph_size32)
    else $error("32-bit write not passed to peripheral");
  rd_two_wait_a: assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    issue_rd && p_drd_g |-> !rd_ready ##1 (periph_rd && !rd_ready) [*2]
    ##1 (periph_rd && rd_ready))
    else $error("peripheral read wait states wrong");
  wr_zero_wait_a: assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    issue_wr |-> wr_ready ##1 periph_wr)
    else $error("peripheral write not zero-wait");
  prot_gap_a: assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    periph_wr && $past(prot_q) |=> !$rose(periph_rd))
    else $error("read followed protected write without alignment");
  stall_retry_a: assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    rw_same ##1 rd_req && r_mem && !wr_req |-> rd_ready)
    else $error("stalled read not granted on retry");
  cov_rw_c: cover property (@(posedge ref_clk) rw_same ##1 rd_ready);
  cov_prd_c: cover property (@(posedge ref_clk) issue_rd ##3 p_done);
  cov_bad_c: cover property (@(posedge ref_clk) p_bad);
  cov_prot_c: cover property (@(posedge ref_clk) hold_q && rd_req &&
                              !r_mem);
endmodule

// ==== verif/target_model.sv ====
`timescale 1ns/100ps
module target_model (
  // Clock
  input logic ref_clk,
  // Memory side
  input logic [1:0] mem_cs,
  input logic [1:0][31:0] mem_addr,
  output logic [1:0][31:0] mem_rdata,
  // Peripheral side
  input logic periph_rd,
  input logic [15:0] periph_addr,
  output logic [31:0] periph_rdata
);
  logic [15:0] cnt_q;
  // Moving pattern so an idle line never repeats a stale word
  initial cnt_q = 16'h0;
  always @(posedge ref_clk) begin
    cnt_q <= cnt_q + 16'h1;
  end
  assign mem_rdata[0] = mem_cs[0] ? mem_addr[0] ^ 32'h5a5a0000 :
                                    {cnt_q, ~cnt_q};
  assign mem_rdata[1] = mem_cs[1] ? mem_addr[1] ^ 32'ha5a50000 :
                                    {~cnt_q, cnt_q};
  // read data only while the strobe stands
  assign periph_rdata = periph_rd ? {16'hc3c3, periph_addr} : {cnt_q, cnt_q};
endmodule

// ==== verif/memory_bus_priority_bridge_tb.sv ====
`timescale 1ns/100ps
module memory_bus_priority_bridge_tb;
  logic ref_clk, reset_n, prot_en;
  logic fetch_req, fetch_prog, fetch_size32, rd_req, rd_size32;
  logic wr_req, wr_prog, wr_size32;
  logic [21:0] fetch_addr;
  logic [31:0] rd_addr, wr_addr, wr_data, a, b, periph_wdata, periph_rdata;
  logic fetch_ready, fetch_err, rd_ready, rd_err, wr_ready, wr_err;
  logic [31:0] fetch_rdata, rd_rdata;
  logic [1:0] mem_cs, mem_we, mem_size32;
  logic [1:0][31:0] mem_addr, mem_wdata, mem_rdata;
  logic periph_wr, periph_rd, periph_size32;
  logic [15:0] periph_addr;
  int fail_count, compares, seed, cycles, n;
  memory_bus_priority_bridge dut (.ref_clk(ref_clk), .reset_n(reset_n),
    .fetch_req(fetch_req), .fetch_prog(fetch_prog),
    .fetch_size32(fetch_size32), .fetch_addr(fetch_addr),
    .fetch_ready(fetch_ready), .fetch_err(fetch_err),
    .fetch_rdata(fetch_rdata), .rd_req(rd_req), .rd_size32(rd_size32),
    .rd_addr(rd_addr), .rd_ready(rd_ready), .rd_err(rd_err),
    .rd_rdata(rd_rdata), .wr_req(wr_req), .wr_prog(wr_prog),
    .wr_size32(wr_size32), .wr_addr(wr_addr), .wr_data(wr_data),
    .wr_ready(wr_ready), .wr_err(wr_err), .mem_cs(mem_cs),
    .mem_we(mem_we), .mem_size32(mem_size32), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .prot_en(prot_en),
    .periph_wr(periph_wr), .periph_rd(periph_rd),
    .periph_size32(periph_size32), .periph_addr(periph_addr),
    .periph_wdata(periph_wdata), .periph_rdata(periph_rdata));
  target_model far_side (.ref_clk(ref_clk), .mem_cs(mem_cs),
    .mem_addr(mem_addr), .mem_rdata(mem_rdata), .periph_rd(periph_rd),
    .periph_addr(periph_addr), .periph_rdata(periph_rdata));
  // Expected target answers
  function automatic logic [31:0] mexp(input logic i, input logic [31:0] x);
    return x ^ (i ? 32'ha5a50000 : 32'h5a5a0000);
  endfunction
  function automatic logic [31:0] pexp(input logic [31:0] x);
    return {16'hc3c3, x[15:0]};
  endfunction
  task automatic chk(input string what, input logic [31:0] seen, exp);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD %s exp %h seen %h", what, exp, seen);
    end
  endtask
  task results;
    $display("mismatches %0d compares %0d", fail_count, compares);
    if (fail_count == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // Peripheral read: three strobe cycles, answer in the last
  task automatic pread(input logic [31:0] x, input logic s);
    @(posedge ref_clk);
    rd_req <= 1'b1; rd_addr <= x; rd_size32 <= s;
    #1 chk("rd_ready c0", rd_ready, 0);
    for (int k = 1; k <= 3; k++) begin
      @(posedge ref_clk);
      #1 chk("periph_rd", periph_rd, 1);
      chk("rd_ready", rd_ready, k == 3);
    end
    chk("periph_addr", periph_addr, x[15:0]);
    chk("periph_size32", periph_size32, s);
    chk("rd_rdata", rd_rdata, pexp(x));
    @(posedge ref_clk);
    rd_req <= 1'b0;
    #1 chk("periph_rd end", periph_rd, 0);
  endtask
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  // Hang guard
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      results();
    end
  end
  initial begin
    {reset_n, fetch_req, fetch_prog, fetch_size32, rd_req, rd_size32} = 0;
    {wr_req, wr_prog, wr_size32, prot_en} = 0;
    {fetch_addr, rd_addr, wr_addr, wr_data} = 0;
    seed = 62788;
    repeat (10) @(posedge ref_clk);
    reset_n <= 1'b1;
    prot_en <= 1'b1;
    // Random triple traffic, one target each, all done in one cycle
    for (int i = 0; i < 24; i++) begin
      @(posedge ref_clk);
      a = 32'h8000 | $random(seed);
      b = 32'h6000 | ($random(seed) & 32'hffc);
      fetch_req <= 1'b1; fetch_addr <= a[21:0] & 22'h5fff;
      rd_req <= 1'b1; rd_size32 <= 1'b1; rd_addr <= a;
      wr_req <= 1'b1; wr_size32 <= 1'b1; wr_addr <= b; wr_data <= ~a;
      #1 chk("all ready", {fetch_ready, rd_ready, wr_ready}, 3'h7);
      chk("rd_rdata", rd_rdata, mexp(1, a));
      chk("fetch_rdata", fetch_rdata, mexp(0, {10'h0, fetch_addr}));
      chk("mem_addr1", mem_addr[1], a);
      chk("errs", {fetch_err, rd_err, wr_err}, 3'h0);
      @(posedge ref_clk);
      {fetch_req, rd_req, wr_req} <= 3'h0;
      #1 chk("periph_wr", periph_wr, 1);
      chk("periph_wdata", periph_wdata, ~a);
      chk("periph_addr", periph_addr, b[15:0]);
    end
    // Contention at one memory, both write and read classes
    for (int p = 0; p < 2; p++) begin
      @(posedge ref_clk);
      wr_req <= 1'b1; wr_prog <= p; wr_addr <= 32'h9000; wr_data <= 32'h5;
      rd_req <= 1'b1; rd_addr <= 32'h9004;
      fetch_req <= 1'b1; fetch_prog <= p; fetch_addr <= 22'h9008;
      #1 chk("win wr", {wr_ready, rd_ready, fetch_ready}, 3'h4);
      chk("mem_we", mem_we[1], 1);
      chk("mem_wdata", mem_wdata[1], 32'h5);
      chk("mem_size32", mem_size32[1], wr_size32);
      @(posedge ref_clk);
      wr_req <= 1'b0;
      #1 chk("win rd", {rd_ready, fetch_ready}, 2'h2);
      chk("rd_rdata", rd_rdata, mexp(1, 32'h9004));
      @(posedge ref_clk);
      rd_req <= 1'b0;
      #1 chk("fetch late", fetch_ready, 1);
      chk("fetch_rdata", fetch_rdata, mexp(1, 32'h9008));
      @(posedge ref_clk);
      fetch_req <= 1'b0;
    end
    pread(32'h7010, 1'b0);
    pread(32'h6024, 1'b1);
    // Wide access to the legacy region is refused at once
    @(posedge ref_clk);
    rd_req <= 1'b1; rd_size32 <= 1'b1; rd_addr <= 32'h7020;
    #1 chk("legacy err", {rd_ready, rd_err}, 2'h3);
    @(posedge ref_clk);
    rd_req <= 1'b0;
    #1 chk("no strobe", periph_rd, 0);
    // Wide write to the legacy region is refused as well
    @(posedge ref_clk);
    wr_req <= 1'b1;
    wr_size32 <= 1'b1;
    wr_addr <= 32'h7030;
    #1 chk("legacy wr err", {wr_ready, wr_err}, 2'h3);
    @(posedge ref_clk);
    wr_req <= 1'b0;
    #1 chk("no wr strobe", periph_wr, 0);
    // Protected write then read keeps program order
    @(posedge ref_clk);
    wr_req <= 1'b1; wr_size32 <= 1'b0; wr_addr <= 32'h6040;
    rd_req <= 1'b1; rd_size32 <= 1'b0; rd_addr <= 32'h6044;
    #1 chk("wr first", {wr_ready, rd_ready}, 2'h2);
    @(posedge ref_clk);
    wr_req <= 1'b0;
    #1 chk("aligned", {periph_wr, periph_rd}, 2'h2);
    n = 0;
    while (rd_ready !== 1'b1 && n < 8) begin
      @(posedge ref_clk);
      #1 n++;
    end
    chk("rd after wr", rd_rdata, pexp(32'h6044));
    @(posedge ref_clk);
    rd_req <= 1'b0;
    repeat (2) @(posedge ref_clk);
    results();
  end
endmodule
